// file: logic/fawp_pkg.sv
// Constants for the flash access and write protection block.
// Assumes a 16-bit register port with word addresses as byte offsets.
package fawp_pkg;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned ADDR_W = 24;
    localparam int unsigned CHAIN_N = 16;
    localparam int unsigned SECT_N = 17;
    localparam logic [23:0] OFS_WP_X_LO = 24'h0EDFB0;
    localparam logic [23:0] OFS_WP_X_HI = 24'h0EDFB2;
    localparam logic [23:0] OFS_WP_I_LO = 24'h0EDFB4;
    localparam logic [23:0] OFS_WP_I_HI = 24'h0EDFB6;
    localparam logic [23:0] OFS_ACC_WORD = 24'h0EDFB8;
    localparam logic [23:0] OFS_DISABLE = 24'h0EDFBC;
    localparam logic [23:0] OFS_REENABLE = 24'h0EDFBE;
    localparam logic [23:0] OFS_CTRL = 24'h0EDF00;
    localparam logic [23:0] OFS_STATUS = 24'h0EDF02;
    localparam logic [15:0] RST_FUSE = 16'hFFFF;
    localparam int unsigned ACC_BIT = 0;
    localparam int unsigned DBG_BIT = 1;
    localparam int unsigned CTRL_SPR_BIT = 8;
    localparam int unsigned CTRL_START_BIT = 15;
    localparam logic [15:0] DUMMY_DATA = 16'h0000;
    typedef enum logic [2:0]
    {
        FAWP_SRC_PRIMARY = 3'h0,
        FAWP_SRC_SECONDARY = 3'h1,
        FAWP_SRC_INTERNAL_RAM = 3'h2,
        FAWP_SRC_EXTENSION_RAM = 3'h3,
        FAWP_SRC_EXT = 3'h4,
        FAWP_SRC_PEC = 3'h5
    } fawp_src_t;
    typedef enum logic [1:0]
    {
        FAWP_ST_LOAD = 2'b01,
        FAWP_ST_RUN = 2'b10
    } fawp_state_t;
endpackage : fawp_pkg

// file: logic/fawp_top.sv
// Access and write protection for a dual-module flash: fuse words, their
// volatile copies and access arbitration against the fetch source.
// Assumes a fuse image on fuse_* inputs that is valid at reset release.
// Summary of operation
// - Disable low, enable high: ignore access protect
// - Disable zero needs debug and access fuses
// - Disable x needs enable x-1 programmed
// - Enable x low, disable x+1 high: restore
// - Enable x needs disable x programmed
// - Protected data access only from primary
// - Sixteen disable and re-enable pairs at most
// - Internal RAM writes to protected flash dropped
// - Internal RAM reads get dummy data
// - Event controller reads blocked while protected
// - Other sources denied reads, jumps allowed
// - Control writes only from primary when protected
// - Secondary flash never access protected
// - Zero sector bit blocks program and erase
// - Set protection writing one clears temporarily
// - Access unprotect only from flash code
// - Reset or writing zero restores protection
// - Other bank may update protected flash
// - Only volatile copy goes to one
// - Clearing select cancels pending operation
`timescale 1ns/100ps
module fawp_top
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [15:0] fuse_wp_x_lo,
    input wire logic [15:0] fuse_wp_x_hi,
    input wire logic [15:0] fuse_wp_i_lo,
    input wire logic [15:0] fuse_wp_i_hi,
    input wire logic [15:0] fuse_acc_word,
    input wire logic [15:0] fuse_disable,
    input wire logic [15:0] fuse_reenable,
    input wire logic [23:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic [2:0] reg_src,
    input wire logic [23:0] sp_addr,
    input wire logic [15:0] sp_data,
    input wire logic acc_req,
    input wire logic acc_write,
    input wire logic acc_fetch,
    input wire logic acc_primary,
    input wire logic [2:0] acc_src,
    input wire logic [15:0] acc_flash_rdata,
    output logic acc_grant,
    output logic acc_deny,
    output logic [15:0] acc_rdata,
    input wire logic pe_req,
    input wire logic [4:0] pe_sector,
    input wire logic [2:0] pe_src_bank,
    input wire logic [2:0] pe_dst_bank,
    output logic pe_grant,
    output logic pe_deny,
    output logic ready
);

////////////////////////////////////////////////////////////////////////////
// Non-volatile words and volatile copies.

fawp_pkg::fawp_state_t state_r;
logic [15:0] nv_wp_x_lo_r;
logic [15:0] nv_wp_x_hi_r;
logic [15:0] nv_wp_i_lo_r;
logic [15:0] nv_wp_i_hi_r;
logic [15:0] nv_acc_r;
logic [15:0] nv_dis_r;
logic [15:0] nv_ren_r;
logic [15:0] v_wp_x_lo_r;
logic [15:0] v_wp_x_hi_r;
logic [15:0] v_wp_i_lo_r;
logic [15:0] v_wp_i_hi_r;
logic v_acc_r;
logic spr_sel_r;
logic from_flash;
logic from_primary;
logic override;
logic acc_active;
logic sp_go;
logic [15:0] dis_allow;
logic [15:0] ren_allow;
logic [15:0] dis_req;
logic [15:0] ren_req;
logic ctrl_wr_ok;
logic run;
fawp_pkg::fawp_state_t state_nxt;

assign from_primary = (reg_src == fawp_pkg::FAWP_SRC_PRIMARY);
assign from_flash = from_primary
    || (reg_src == fawp_pkg::FAWP_SRC_SECONDARY);

// Control writes are refused from any other source while protection is
// active; the same gate covers the start bit, so a select left armed by
// earlier primary code cannot be fired from RAM.
assign ctrl_wr_ok = from_primary || !acc_active;
assign run = (state_r == fawp_pkg::FAWP_ST_RUN);

// Pair x overrides the access fuse while its disable is spent and its
// re-enable is not; a later re-enable hands control to the next pair.
always_comb
begin
    override = 1'b0;
    for (int i = 0; i < fawp_pkg::CHAIN_N; i++)
    begin
        if (!nv_dis_r[i] && nv_ren_r[i])
        begin
            override = 1'b1;
        end
    end
end

// The chain is monotone, so a spent re-enable with a fresh next disable
// leaves no override set and the fuse acts again.
assign acc_active = !v_acc_r && !override;

always_comb
begin
    dis_allow = '0;
    ren_allow = '0;
    dis_allow[0] = !nv_acc_r[fawp_pkg::DBG_BIT]
        && !nv_acc_r[fawp_pkg::ACC_BIT];
    for (int i = 1; i < fawp_pkg::CHAIN_N; i++)
    begin
        dis_allow[i] = !nv_ren_r[i-1];
    end
    for (int i = 0; i < fawp_pkg::CHAIN_N; i++)
    begin
        ren_allow[i] = !nv_dis_r[i];
    end
end

// A start write with the select bit held launches one set protection.
assign sp_go = run && reg_wr && ctrl_wr_ok
    && (reg_addr == fawp_pkg::OFS_CTRL)
    && reg_wdata[fawp_pkg::CTRL_START_BIT] && spr_sel_r;
assign dis_req = ~sp_data & nv_dis_r & dis_allow;
assign ren_req = ~sp_data & nv_ren_r & ren_allow;

// Loading takes one cycle; an unknown code falls back to loading so the
// copies are refreshed rather than left stale.
always_comb
begin
    case (state_r)
        fawp_pkg::FAWP_ST_LOAD: state_nxt = fawp_pkg::FAWP_ST_RUN;
        fawp_pkg::FAWP_ST_RUN: state_nxt = fawp_pkg::FAWP_ST_RUN;
        default: state_nxt = fawp_pkg::FAWP_ST_LOAD;
    endcase
end

always_ff @(posedge clk)
begin
    if (rst)
    begin
        state_r <= fawp_pkg::FAWP_ST_LOAD;
    end
    else
    begin
        state_r <= state_nxt;
    end
end

always_ff @(posedge clk)
begin
    if (rst)
    begin
        spr_sel_r <= 1'b0;
    end
    else if (sp_go)
    begin
        spr_sel_r <= 1'b0;
    end
    else if (reg_wr && reg_addr == fawp_pkg::OFS_CTRL
        && ctrl_wr_ok)
    begin
        spr_sel_r <= reg_wdata[fawp_pkg::CTRL_SPR_BIT];
    end
end

// Fuses only go from one to zero; a zero bit in the data programs.
// Chain words only take the bits that the order allows; a refused bit
// is dropped without any error flag, since nothing would report it.
always_ff @(posedge clk)
begin
    if (rst)
    begin
        nv_wp_x_lo_r <= fawp_pkg::RST_FUSE;
        nv_wp_x_hi_r <= fawp_pkg::RST_FUSE;
        nv_wp_i_lo_r <= fawp_pkg::RST_FUSE;
        nv_wp_i_hi_r <= fawp_pkg::RST_FUSE;
        nv_acc_r <= fawp_pkg::RST_FUSE;
        nv_dis_r <= fawp_pkg::RST_FUSE;
        nv_ren_r <= fawp_pkg::RST_FUSE;
    end
    else if (state_r == fawp_pkg::FAWP_ST_LOAD)
    begin
        nv_wp_x_lo_r <= fuse_wp_x_lo;
        nv_wp_x_hi_r <= fuse_wp_x_hi;
        nv_wp_i_lo_r <= fuse_wp_i_lo;
        nv_wp_i_hi_r <= fuse_wp_i_hi;
        nv_acc_r <= fuse_acc_word;
        nv_dis_r <= fuse_disable;
        nv_ren_r <= fuse_reenable;
    end
    else if (sp_go)
    begin
        case (sp_addr)
            fawp_pkg::OFS_WP_X_LO: nv_wp_x_lo_r <= nv_wp_x_lo_r & sp_data;
            fawp_pkg::OFS_WP_X_HI: nv_wp_x_hi_r <= nv_wp_x_hi_r & sp_data;
            fawp_pkg::OFS_WP_I_LO: nv_wp_i_lo_r <= nv_wp_i_lo_r & sp_data;
            fawp_pkg::OFS_WP_I_HI: nv_wp_i_hi_r <= nv_wp_i_hi_r & sp_data;
            fawp_pkg::OFS_ACC_WORD: nv_acc_r <= nv_acc_r & sp_data;
            fawp_pkg::OFS_DISABLE: nv_dis_r <= nv_dis_r & ~dis_req;
            fawp_pkg::OFS_REENABLE: nv_ren_r <= nv_ren_r & ~ren_req;
            default: nv_acc_r <= nv_acc_r;
        endcase
    end
end

// Volatile copies follow the set protection data directly, so ones
// unprotect until reset while the fuse words keep their zeros.
// The access copy is one bit: the debug bit has no temporary form, so
// only the access bit is mirrored.
always_ff @(posedge clk)
begin
    if (rst)
    begin
        v_wp_x_lo_r <= '0;
        v_wp_x_hi_r <= '0;
        v_wp_i_lo_r <= '0;
        v_wp_i_hi_r <= '0;
        v_acc_r <= 1'b0;
    end
    else if (state_r == fawp_pkg::FAWP_ST_LOAD)
    begin
        v_wp_x_lo_r <= fuse_wp_x_lo;
        v_wp_x_hi_r <= fuse_wp_x_hi;
        v_wp_i_lo_r <= fuse_wp_i_lo;
        v_wp_i_hi_r <= fuse_wp_i_hi;
        v_acc_r <= fuse_acc_word[fawp_pkg::ACC_BIT];
    end
    else if (sp_go)
    begin
        case (sp_addr)
            fawp_pkg::OFS_WP_X_LO: v_wp_x_lo_r <= sp_data;
            fawp_pkg::OFS_WP_X_HI: v_wp_x_hi_r <= sp_data;
            fawp_pkg::OFS_WP_I_LO: v_wp_i_lo_r <= sp_data;
            fawp_pkg::OFS_WP_I_HI: v_wp_i_hi_r <= sp_data;
            fawp_pkg::OFS_ACC_WORD:
            begin
                if (from_flash || !sp_data[fawp_pkg::ACC_BIT])
                begin
                    v_acc_r <= sp_data[fawp_pkg::ACC_BIT];
                end
            end
            default: v_acc_r <= v_acc_r;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////
// Data access arbitration.

// A denied request is answered in the same cycle as a granted one, so
// the answer timing never tells protected code apart from open code.
logic acc_ok;
assign acc_ok = !acc_primary
    || acc_fetch
    || !acc_active
    || (acc_src == fawp_pkg::FAWP_SRC_PRIMARY);

always_ff @(posedge clk)
begin
    if (rst)
    begin
        acc_grant <= 1'b0;
        acc_deny <= 1'b0;
        acc_rdata <= '0;
    end
    else
    begin
        acc_grant <= acc_req && acc_ok && state_r == fawp_pkg::FAWP_ST_RUN;
        acc_deny <= acc_req && !(acc_ok && state_r == fawp_pkg::FAWP_ST_RUN);
        // Denied writes are dropped without a bus error.
        // A write never touches the read data, which holds the last answer.
        if (acc_req && !acc_write && acc_ok)
        begin
            acc_rdata <= acc_flash_rdata;
        end
        else if (acc_req && !acc_write)
        begin
            acc_rdata <= fawp_pkg::DUMMY_DATA;
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// Program and erase gating by sector.

logic [16:0] sect_wp;
logic sect_ok;
logic bank_ok;
// Only the volatile copies gate program and erase, so a temporary
// unprotect takes effect at once and lapses at the next reset.
assign sect_wp = {v_wp_x_hi_r[1:0], v_wp_x_lo_r[2:0],
    v_wp_i_hi_r[1:0], v_wp_i_lo_r[9:0]};
// Sectors are numbered primary bank 0, bank 1, then secondary banks.
assign sect_ok = (pe_sector < 5'(fawp_pkg::SECT_N))
    && sect_wp[pe_sector];
// Updates must come from another bank; the same bank is refused outright.
assign bank_ok = (pe_src_bank != pe_dst_bank);

always_ff @(posedge clk)
begin
    if (rst)
    begin
        pe_grant <= 1'b0;
        pe_deny <= 1'b0;
    end
    else
    begin
        pe_grant <= pe_req && sect_ok && bank_ok;
        pe_deny <= pe_req && !(sect_ok && bank_ok);
    end
end

////////////////////////////////////////////////////////////////////////////
// Register reads; the volatile copies are never read back here.
// The status word reports the live decision so that test code can see
// the chain override; software must still keep its own record.

logic [15:0] status_word;
assign status_word = {14'h0000, override, acc_active};

always_ff @(posedge clk)
begin
    if (rst)
    begin
        reg_rdata <= '0;
        ready <= 1'b0;
    end
    else
    begin
        ready <= (state_r == fawp_pkg::FAWP_ST_RUN);
        if (reg_rd)
        begin
            case (reg_addr)
                fawp_pkg::OFS_WP_X_LO: reg_rdata <= nv_wp_x_lo_r;
                fawp_pkg::OFS_WP_X_HI: reg_rdata <= nv_wp_x_hi_r;
                fawp_pkg::OFS_WP_I_LO: reg_rdata <= nv_wp_i_lo_r;
                fawp_pkg::OFS_WP_I_HI: reg_rdata <= nv_wp_i_hi_r;
                fawp_pkg::OFS_ACC_WORD: reg_rdata <= nv_acc_r;
                fawp_pkg::OFS_DISABLE: reg_rdata <= nv_dis_r;
                fawp_pkg::OFS_REENABLE: reg_rdata <= nv_ren_r;
                // Only the select bit reads back; start clears itself.
                fawp_pkg::OFS_CTRL:
                    reg_rdata <= {7'h00, spr_sel_r, 8'h00};
                fawp_pkg::OFS_STATUS:
                    reg_rdata <= status_word;
                default: reg_rdata <= 16'h0000;
            endcase
        end
        else
        begin
            reg_rdata <= 16'h0000;
        end
    end
end

endmodule : fawp_top

// file: verif/fawp_top_monitor.sv
// Checker for the protection block, bound to its top module.
// Assumes one clock and the synchronous active-high reset.
`timescale 1ns/100ps
module fawp_top_monitor
(
    input wire logic clk,
    input wire logic rst,
    input wire logic acc_req,
    input wire logic acc_write,
    input wire logic acc_fetch,
    input wire logic [2:0] acc_src,
    input wire logic acc_grant,
    input wire logic acc_deny,
    input wire logic [15:0] acc_rdata,
    input wire logic pe_req,
    input wire logic [2:0] pe_src_bank,
    input wire logic [2:0] pe_dst_bank,
    input wire logic pe_grant,
    input wire logic pe_deny,
    input wire logic ready
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    sequence s_acc;
        acc_req && ready;
    endsequence
    sequence s_pe;
        pe_req && ready;
    endsequence
    property p_prim;
        s_acc ##0 (acc_src == fawp_pkg::FAWP_SRC_PRIMARY) |=> acc_grant;
    endproperty
    property p_jump;
        s_acc ##0 (acc_fetch && acc_src != fawp_pkg::FAWP_SRC_PEC)
            |=> acc_grant;
    endproperty
    chk_acc_answer: assert property (s_acc |=> acc_grant ^ acc_deny)
        else $error("access request not answered once");
    chk_acc_cause: assert property
        ((acc_grant || acc_deny) |-> $past(acc_req))
        else $error("access answer without request");
    chk_primary_grant: assert property (p_prim)
        else $error("primary fetch source refused");
    chk_jump_grant: assert property (p_jump)
        else $error("jump refused");
    chk_deny_dummy: assert property
        (acc_deny && !$past(acc_write) |-> acc_rdata == fawp_pkg::DUMMY_DATA)
        else $error("denied read shows stored data");
    chk_pe_answer: assert property (s_pe |=> pe_grant ^ pe_deny)
        else $error("program request not answered once");
    chk_pe_bank: assert property
        (s_pe ##0 (pe_src_bank == pe_dst_bank) |=> pe_deny)
        else $error("same bank program granted");
    chk_ready_rise: assert property ($fell(rst) |=> !ready ##1 ready)
        else $error("ready timing after reset wrong");
endmodule : fawp_top_monitor
bind fawp_top fawp_top_monitor u_mon (.clk(clk), .rst(rst), .acc_req(acc_req),
    .acc_write(acc_write), .acc_fetch(acc_fetch), .acc_src(acc_src),
    .acc_grant(acc_grant), .acc_deny(acc_deny), .acc_rdata(acc_rdata),
    .pe_req(pe_req), .pe_src_bank(pe_src_bank), .pe_dst_bank(pe_dst_bank),
    .pe_grant(pe_grant), .pe_deny(pe_deny), .ready(ready));

// file: verif/fawp_flash_model.sv
// Flash array stand-in that serves the word the block forwards.
// Assumes access requests are one-cycle pulses.
`timescale 1ns/100ps
module fawp_flash_model
(
    input wire logic clk,
    input wire logic acc_req,
    output logic [15:0] acc_flash_rdata
);
    logic busy_r;
    initial busy_r = 1'b0;
    initial acc_flash_rdata = 16'hA5C3;
    // The word moves every idle cycle, so a late sample shows as wrong data.
    always @(posedge clk)
    begin
        busy_r <= acc_req;
        if (!acc_req && !busy_r)
            acc_flash_rdata <= {acc_flash_rdata[14:0],
                ^acc_flash_rdata[15:13]};
    end
endmodule : fawp_flash_model

// file: verif/flash_access_write_protection_tb_top.sv
// Bench for the protection block with a small model of its rules.
// Assumes the flash stand-in beside the block and the bound checker.
`timescale 1ns/100ps
module flash_access_write_protection_tb_top;
    logic clk, rst, reg_wr, reg_rd, acc_req, acc_write, acc_fetch;
    logic acc_primary, pe_req, acc_grant, acc_deny, pe_grant, pe_deny, ready;
    logic [15:0] fuse_acc_word, fuse_disable, fuse_reenable, fuse_wp_i_lo;
    logic [15:0] fuse_wp_x_hi;
    logic [15:0] reg_wdata, sp_data, reg_rdata, acc_rdata, acc_flash_rdata;
    logic [23:0] reg_addr, sp_addr;
    logic [2:0] reg_src, acc_src, pe_src_bank, pe_dst_bank, b;
    logic [4:0] pe_sector;
    logic [31:0] lfsr;
    logic [15:0] md, me;
    int mt, mw, failures, checks_done;
    fawp_top dut_u (.clk(clk), .rst(rst), .fuse_wp_x_lo(16'hFFFF),
        .fuse_wp_x_hi(fuse_wp_x_hi), .fuse_wp_i_lo(fuse_wp_i_lo),
        .fuse_wp_i_hi(16'hFFFF), .fuse_acc_word(fuse_acc_word),
        .fuse_disable(fuse_disable), .fuse_reenable(fuse_reenable),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_src(reg_src),
        .sp_addr(sp_addr), .sp_data(sp_data), .acc_req(acc_req),
        .acc_write(acc_write), .acc_fetch(acc_fetch),
        .acc_primary(acc_primary), .acc_src(acc_src),
        .acc_flash_rdata(acc_flash_rdata), .acc_grant(acc_grant),
        .acc_deny(acc_deny), .acc_rdata(acc_rdata), .pe_req(pe_req),
        .pe_sector(pe_sector), .pe_src_bank(pe_src_bank),
        .pe_dst_bank(pe_dst_bank), .pe_grant(pe_grant), .pe_deny(pe_deny),
        .ready(ready));
    fawp_flash_model flash_u (.clk(clk), .acc_req(acc_req),
        .acc_flash_rdata(acc_flash_rdata));
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] nxt(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : nxt
    function automatic int prot();
        for (int i = 0; i < 16; i++)
            if (!md[i] && me[i])
                return 0;
        return mt;
    endfunction : prot
    task automatic check(input string n, input logic [15:0] s,
        input logic [15:0] e);
        checks_done++;
        if (s !== e)
        begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask : check
    task automatic summarize();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : summarize
    task automatic start(input logic [15:0] a, d, e);
        @(posedge clk);
        rst <= 1'b1;
        fuse_acc_word <= a;
        fuse_disable <= d;
        fuse_reenable <= e;
        md = d;
        me = e;
        mt = !a[0];
        mw = {15'h0, fuse_wp_x_hi[1:0], 5'h1F, fuse_wp_i_lo[9:0]};
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : start
    task automatic regw(input logic [23:0] a, input logic [15:0] d,
        input logic [2:0] s);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_src <= s;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : regw
    task automatic regr(input logic [23:0] a, input logic [15:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 check("reg_rdata", reg_rdata, e);
    endtask : regr
    task automatic setprot(input logic [23:0] a, input logic [15:0] d,
        input logic [2:0] s);
        int ok;
        ok = (s == 3'h0 || !prot());
        sp_addr <= a;
        sp_data <= d;
        regw(fawp_pkg::OFS_CTRL, 16'h0100, s);
        regw(fawp_pkg::OFS_CTRL, 16'h8100, s);
        if (ok && a == fawp_pkg::OFS_ACC_WORD && (!d[0] || s < 3'h2))
            mt = !d[0];
        if (ok && a == fawp_pkg::OFS_WP_I_LO)
            mw[9:0] = d[9:0];
        for (int i = 0; i < 16; i++)
        begin
            if (ok && a == fawp_pkg::OFS_DISABLE && !d[i] &&
                (i == 0 ? fuse_acc_word[1:0] == 2'h0 : !me[i - 1]))
                md[i] = 1'b0;
            if (ok && a == fawp_pkg::OFS_REENABLE && !d[i] && !md[i])
                me[i] = 1'b0;
        end
    endtask : setprot
    task automatic acc(input int w, f, p, input logic [2:0] s);
        int ok;
        logic [15:0] d;
        ok = (s == 3'h0 || f || !p || !prot());
        @(posedge clk);
        acc_write <= w[0];
        acc_fetch <= f[0];
        acc_primary <= p[0];
        acc_src <= s;
        acc_req <= 1'b1;
        @(posedge clk);
        acc_req <= 1'b0;
        #1 d = acc_flash_rdata;
        check("acc_grant", {15'h0, acc_grant}, {15'h0, ok[0]});
        check("acc_deny", {15'h0, acc_deny}, {15'h0, !ok[0]});
        if (!w && !f)
            check("acc_rdata", acc_rdata, ok ? d : 16'h0000);
    endtask : acc
    task automatic pe(input int sec, input logic [2:0] sb, db);
        @(posedge clk);
        pe_sector <= sec[4:0];
        pe_src_bank <= sb;
        pe_dst_bank <= db;
        pe_req <= 1'b1;
        @(posedge clk);
        pe_req <= 1'b0;
        #1 check("pe_grant", {15'h0, pe_grant},
            {15'h0, mw[sec] && sb != db});
    endtask : pe
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Far longer than the few hundred cycles the sequence needs.
    initial
    begin
        #200000 failures++;
        summarize();
    end
    initial
    begin
        failures = 0;
        checks_done = 0;
        rst = 1'b1;
        lfsr = 32'h442B;
        {reg_wr, reg_rd, acc_req, acc_write, acc_fetch, acc_primary} = '0;
        {pe_req, reg_addr, reg_wdata, sp_addr, sp_data, reg_src} = '0;
        {acc_src, pe_sector, pe_src_bank, pe_dst_bank} = '0;
        {fuse_acc_word, fuse_disable, fuse_reenable} = '1;
        fuse_wp_i_lo = 16'hFDFE;
        fuse_wp_x_hi = 16'hFFFE;
        start(16'hFFFE, 16'hFFFF, 16'hFFFF);
        regr(fawp_pkg::OFS_DISABLE, 16'hFFFF);
        regr(fawp_pkg::OFS_REENABLE, 16'hFFFF);
        regr(24'h0EDF40, 16'h0000);
        for (int i = 0; i < 24; i++)
        begin
            lfsr = nxt(lfsr);
            acc(lfsr[0], lfsr[1], lfsr[2], lfsr[5:3] % 3'h5);
        end
        acc(0, 0, 1, 3'h5);
        for (int i = 0; i < 18; i++)
        begin
            lfsr = nxt(lfsr);
            b = (i % 17 < 10) ? 3'h0 : (i % 17 < 12) ? 3'h1 : 3'h2;
            b = (i % 17 > 14) ? 3'h3 : b;
            pe(i % 17, (i == 17) ? b : b + 3'h1 + {2'h0, lfsr[0]},
                b);
        end
        setprot(fawp_pkg::OFS_ACC_WORD, 16'hFFFF, 3'h2);
        acc(0, 0, 1, 3'h2);
        setprot(fawp_pkg::OFS_ACC_WORD, 16'hFFFF, 3'h0);
        acc(0, 0, 1, 3'h2);
        acc(1, 0, 1, 3'h5);
        regr(fawp_pkg::OFS_ACC_WORD, 16'hFFFE);
        setprot(fawp_pkg::OFS_ACC_WORD, 16'hFFFE, 3'h0);
        acc(0, 0, 1, 3'h2);
        setprot(fawp_pkg::OFS_WP_I_LO, 16'hFFFF, 3'h0);
        pe(0, 3'h4, 3'h0);
        sp_data <= 16'hFFFE;
        regw(fawp_pkg::OFS_CTRL, 16'h0100, 3'h0);
        regw(fawp_pkg::OFS_CTRL, 16'h0000, 3'h0);
        regw(fawp_pkg::OFS_CTRL, 16'h8000, 3'h0);
        pe(0, 3'h4, 3'h0);
        start(16'hFFFE, 16'hFFFF, 16'hFFFF);
        pe(0, 3'h4, 3'h0);
        // Select armed by primary code must not be started from RAM.
        sp_addr <= fawp_pkg::OFS_WP_I_LO;
        sp_data <= 16'hFFFF;
        regw(fawp_pkg::OFS_CTRL, 16'h0100, 3'h0);
        regr(fawp_pkg::OFS_CTRL, 16'h0100);
        regw(fawp_pkg::OFS_CTRL, 16'h8100, 3'h2);
        pe(0, 3'h4, 3'h0);
        setprot(fawp_pkg::OFS_DISABLE, 16'hFFFE, 3'h0);
        regr(fawp_pkg::OFS_DISABLE, md);
        setprot(fawp_pkg::OFS_REENABLE, 16'hFFFE, 3'h0);
        regr(fawp_pkg::OFS_REENABLE, me);
        start(16'hFFFC, 16'hFFFF, 16'hFFFF);
        setprot(fawp_pkg::OFS_DISABLE, 16'hFFFE, 3'h0);
        regr(fawp_pkg::OFS_DISABLE, md);
        acc(0, 0, 1, 3'h2);
        regr(fawp_pkg::OFS_STATUS, 16'h0002);
        setprot(fawp_pkg::OFS_DISABLE, 16'hFFFA, 3'h0);
        regr(fawp_pkg::OFS_DISABLE, md);
        setprot(fawp_pkg::OFS_REENABLE, 16'hFFFE, 3'h0);
        acc(0, 0, 1, 3'h2);
        regr(fawp_pkg::OFS_STATUS, 16'h0001);
        start(16'hFFFC, 16'h0000, 16'h7FFF);
        acc(0, 0, 1, 3'h2);
        summarize();
    end
endmodule : flash_access_write_protection_tb_top
